/* File: include/serw_pkg.sv */
// constants, field layouts and states of the serial eeprom command block
`default_nettype none

package serw_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned PAGE_W = 5;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned ROW_W = ADDR_W - PAGE_W;
  localparam logic [12:0] ADDR_RST = 13'h0000;

  // ************************************************************
  // device address byte layout
  // ************************************************************
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int unsigned DEV_TYPE_LSB = 4;
  localparam int unsigned DEV_CS_LSB = 1;
  localparam int unsigned DEV_RW_BIT = 0;

  // ************************************************************
  // bit counter marks within a nine clock frame
  // ************************************************************
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_END = 4'h9;

  // ************************************************************
  // programming time
  // ************************************************************
  localparam int unsigned PROGRAM_CYCLE_TIME_MS = 5;
  localparam int unsigned CLK_SYS_KHZ = 40000;
  localparam int unsigned PROG_CYCLES_DEF =
    PROGRAM_CYCLE_TIME_MS * CLK_SYS_KHZ;

  // ************************************************************
  // link states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_AHI  = 3'b010,
    ST_ALO  = 3'b011,
    ST_WDAT = 3'b100,
    ST_RDAT = 3'b101
  } serw_state_e;

endpackage : serw_pkg

`default_nettype wire

/* File: rtl/serw_top.sv */
// serial eeprom command logic: two-wire link, page buffer, array, timer
`default_nettype none

// Overview of operation
// - write address acked, then two word-address bytes, each acked low
// - every received write data byte is acked low
// - stop after write data starts the timed programming cycle
// - while programming, no bus response at all
// - page write takes up to 32 bytes, each acked
// - only low five address bits count up during writes
// - page address wraps to first byte of same page
// - address polling acked only after programming completes
// - read selected by direction bit one in device address
// - address counter holds last accessed address plus one
// - read counter wraps from top of array to zero
// - current read sends byte at counter after address ack
// - master ack during read fetches next byte, counter increments
// - sequential read continues from array start after top address
// - master no-ack then stop ends read, data line released
// - device byte: 1010, three chip selects, direction bit
// - address mismatch: no ack, back to standby
// - programming lasts the program cycle time, 5 ms
// - receiver acks by pulling data low on ninth clock
module serw_top #(
  parameter int unsigned PROG_CYCLES = serw_pkg::PROG_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_link,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic chip_select_bit_high,
  input wire logic chip_select_bit_mid,
  input wire logic chip_select_bit_low,
  output logic program_busy
);
  import serw_pkg::*;

  // ************************************************************
  // address arithmetic
  // ************************************************************
  function automatic logic [12:0] page_inc(input logic [12:0] a);
    page_inc = {a[12:5], 5'(a[4:0] + 5'h01)};
  endfunction : page_inc

  function automatic logic [12:0] array_inc(input logic [12:0] a);
    array_inc = 13'(a + 13'h0001);
  endfunction : array_inc

  // ************************************************************
  // declarations
  // ************************************************************
  logic rst_link_meta_ff;
  logic rst_link_ff;
  logic scl_meta_ff;
  logic scl_ff;
  logic scl_prev_ff;
  logic sda_meta_ff;
  logic sda_ff;
  logic sda_prev_ff;
  logic [2:0] cs_meta_ff;
  logic [2:0] cs_ff;
  logic done_meta_ff;
  logic done_sync_ff;
  logic done_prev_ff;
  logic req_meta_ff;
  logic req_sync_ff;
  logic req_prev_ff;
  logic req_tgl_ff;
  logic done_tgl_ff;
  logic link_busy_ff;
  logic program_busy_ff;
  logic [31:0] prog_cnt_ff;
  logic sda_o_ff;
  logic sda_oe_ff;
  serw_state_e state_ff;
  serw_state_e go_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shreg_ff;
  logic [7:0] rx_byte;
  logic ack_ok_ff;
  logic wr_pend_ff;
  logic [12:0] addr_ff;
  logic [4:0] addr_hi_ff;
  logic [31:0] pvalid_ff;
  logic [7:0] pbuf_ff [PAGE_BYTES];
  logic [7:0] mem_ff [2**ADDR_W];
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;
  logic done_ev;
  logic req_ev;
  logic dev_match;

  // ************************************************************
  // reset into link domain
  // ************************************************************
  always_ff @(posedge clk_link) begin
    rst_link_meta_ff <= rst;
    rst_link_ff <= rst_link_meta_ff;
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge clk_link) begin
    if (rst_link_ff) begin
      scl_meta_ff <= 1'b1;
      scl_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      cs_meta_ff <= 3'h0;
      cs_ff <= 3'h0;
    end else begin
      scl_meta_ff <= scl_i;
      scl_ff <= scl_meta_ff;
      scl_prev_ff <= scl_ff;
      sda_meta_ff <= sda_i;
      sda_ff <= sda_meta_ff;
      sda_prev_ff <= sda_ff;
      cs_meta_ff <= {chip_select_bit_high, chip_select_bit_mid,
                     chip_select_bit_low};
      cs_ff <= cs_meta_ff;
    end
  end

  // ************************************************************
  // bus events
  // ************************************************************
  assign start_ev = scl_ff & scl_prev_ff & sda_prev_ff & ~sda_ff;
  assign stop_ev = scl_ff & scl_prev_ff & ~sda_prev_ff & sda_ff;
  assign rise_ev = scl_ff & ~scl_prev_ff;
  assign fall_ev = ~scl_ff & scl_prev_ff;
  assign rx_byte = shreg_ff;

  // device byte compare, refused while programming
  assign dev_match = (rx_byte[7:DEV_TYPE_LSB] == DEV_TYPE) &&
                     (rx_byte[3:DEV_CS_LSB] == cs_ff) &&
                     !link_busy_ff;

  // ************************************************************
  // programming done crossing into link domain
  // ************************************************************
  always_ff @(posedge clk_link) begin
    if (rst_link_ff) begin
      done_meta_ff <= 1'b0;
      done_sync_ff <= 1'b0;
      done_prev_ff <= 1'b0;
    end else begin
      done_meta_ff <= done_tgl_ff;
      done_sync_ff <= done_meta_ff;
      done_prev_ff <= done_sync_ff;
    end
  end

  assign done_ev = done_sync_ff ^ done_prev_ff;

  // ************************************************************
  // link protocol
  // ************************************************************
  always_ff @(posedge clk_link) begin
    if (rst_link_ff) begin
      state_ff <= ST_IDLE;
      go_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      shreg_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      addr_ff <= ADDR_RST;
      addr_hi_ff <= 5'h00;
    end else if (start_ev) begin
      state_ff <= ST_DEV;
      cnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
    end else if (stop_ev) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
    end else if (state_ff != ST_IDLE) begin
      if (rise_ev) begin
        if (cnt_ff < CNT_ACK && state_ff != ST_RDAT) begin
          shreg_ff <= {shreg_ff[6:0], sda_ff};
        end
        if (cnt_ff == CNT_ACK && state_ff == ST_RDAT) begin
          ack_ok_ff <= ~sda_ff;
        end
        if (cnt_ff != CNT_END) begin
          cnt_ff <= 4'(cnt_ff + 4'h1);
        end
      end else if (fall_ev) begin
        if (cnt_ff == CNT_ACK) begin
          case (state_ff)
            ST_DEV: begin
              if (dev_match) begin
                sda_oe_ff <= 1'b1;
                go_ff <= rx_byte[DEV_RW_BIT] ? ST_RDAT : ST_AHI;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
            ST_AHI: begin
              addr_hi_ff <= rx_byte[4:0];
              sda_oe_ff <= 1'b1;
              go_ff <= ST_ALO;
            end
            ST_ALO: begin
              addr_ff <= {addr_hi_ff, rx_byte};
              sda_oe_ff <= 1'b1;
              go_ff <= ST_WDAT;
            end
            ST_WDAT: begin
              addr_ff <= page_inc(addr_ff);
              wr_pend_ff <= 1'b1;
              sda_oe_ff <= 1'b1;
              go_ff <= ST_WDAT;
            end
            ST_RDAT: begin
              sda_oe_ff <= 1'b0;
            end
            default: begin
              state_ff <= ST_IDLE;
            end
          endcase
        end else if (cnt_ff == CNT_END) begin
          cnt_ff <= 4'h0;
          if (state_ff == ST_RDAT) begin
            if (ack_ok_ff) begin
              shreg_ff <= mem_ff[addr_ff];
              sda_oe_ff <= ~mem_ff[addr_ff][7];
              addr_ff <= array_inc(addr_ff);
            end else begin
              state_ff <= ST_IDLE;
              sda_oe_ff <= 1'b0;
            end
          end else begin
            state_ff <= go_ff;
            if (go_ff == ST_RDAT) begin
              shreg_ff <= mem_ff[addr_ff];
              sda_oe_ff <= ~mem_ff[addr_ff][7];
              addr_ff <= array_inc(addr_ff);
            end else begin
              sda_oe_ff <= 1'b0;
            end
          end
        end else if (state_ff == ST_RDAT) begin
          shreg_ff <= {shreg_ff[6:0], 1'b0};
          sda_oe_ff <= ~shreg_ff[6];
        end
      end
    end
  end

  // ************************************************************
  // page buffer fill
  // ************************************************************
  always_ff @(posedge clk_link) begin
    if (rst_link_ff) begin
      pvalid_ff <= 32'h00000000;
    end else if (state_ff == ST_ALO && fall_ev && cnt_ff == CNT_ACK) begin
      pvalid_ff <= 32'h00000000;
    end else if (state_ff == ST_WDAT && fall_ev && cnt_ff == CNT_ACK
                 && !start_ev && !stop_ev) begin
      pvalid_ff[addr_ff[4:0]] <= 1'b1;
      pbuf_ff[addr_ff[4:0]] <= rx_byte;
    end
  end

  // ************************************************************
  // programming request and link busy
  // ************************************************************
  always_ff @(posedge clk_link) begin
    if (rst_link_ff) begin
      link_busy_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
    end else if (stop_ev && wr_pend_ff && state_ff == ST_WDAT) begin
      link_busy_ff <= 1'b1;
      req_tgl_ff <= ~req_tgl_ff;
    end else if (done_ev) begin
      link_busy_ff <= 1'b0;
    end
  end

  // ************************************************************
  // array commit at end of programming
  // ************************************************************
  always_ff @(posedge clk_link) begin
    if (done_ev) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pvalid_ff[i]) begin
          mem_ff[{addr_ff[12:5], 5'(i)}] <= pbuf_ff[i];
        end
      end
    end
  end

  // ************************************************************
  // programming request crossing into system domain
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_meta_ff <= 1'b0;
      req_sync_ff <= 1'b0;
      req_prev_ff <= 1'b0;
    end else begin
      req_meta_ff <= req_tgl_ff;
      req_sync_ff <= req_meta_ff;
      req_prev_ff <= req_sync_ff;
    end
  end

  assign req_ev = req_sync_ff ^ req_prev_ff;

  // ************************************************************
  // programming timer
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      program_busy_ff <= 1'b0;
      prog_cnt_ff <= 32'h00000000;
      done_tgl_ff <= 1'b0;
    end else if (!program_busy_ff && req_ev) begin
      program_busy_ff <= 1'b1;
      prog_cnt_ff <= 32'(PROG_CYCLES - 1);
    end else if (program_busy_ff) begin
      if (prog_cnt_ff == 32'h00000000) begin
        program_busy_ff <= 1'b0;
        done_tgl_ff <= ~done_tgl_ff;
      end else begin
        prog_cnt_ff <= 32'(prog_cnt_ff - 32'h00000001);
      end
    end
  end

  // ************************************************************
  // open drain data output
  // ************************************************************
  always_ff @(posedge clk_link) begin
    sda_o_ff <= 1'b0;
  end

  assign sda_o = sda_o_ff;
  assign sda_oe = sda_oe_ff;
  assign program_busy = program_busy_ff;

endmodule : serw_top

`default_nettype wire

/* File: testbench/serw_ctl_model.sv */
// two-wire bus controller model driving clock and data
`default_nettype none
module serw_ctl_model #(
  parameter int unsigned H = 6
) (
  input wire logic clk_link,
  input wire logic sda_w,
  output var logic scl_o,
  output var logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_link);
  endtask : wt
  task automatic start_c;
    sda_low <= 1'b0;
    wt(H);
    scl_o <= 1'b1;
    wt(H);
    sda_low <= 1'b1;
    wt(H);
    scl_o <= 1'b0;
    wt(H);
  endtask : start_c
  task automatic stop_c;
    sda_low <= 1'b1;
    wt(H);
    scl_o <= 1'b1;
    wt(H);
    sda_low <= 1'b0;
    wt(H);
  endtask : stop_c
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    wt(H);
    scl_o <= 1'b1;
    wt(H);
    r = sda_w;
    scl_o <= 1'b0;
    wt(H);
  endtask : bitx
  task automatic byte_io(input logic [7:0] tx, input logic ak,
    output logic [7:0] rx, output logic ar);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(ak, ar);
  endtask : byte_io
endmodule : serw_ctl_model
`default_nettype wire

/* File: testbench/serw_top_chk.sv */
// assertion checker for the serial eeprom command block
`default_nettype none
module serw_top_chk #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_link,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic chip_select_bit_high,
  input wire logic chip_select_bit_mid,
  input wire logic chip_select_bit_low,
  input wire logic program_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // link domain reset stretch
  // ****
  logic [2:0] rst_link_sr;
  logic rst_chk;
  always_ff @(posedge clk_link) begin
    rst_link_sr <= {rst_link_sr[1:0], rst};
  end
  // covers the two flops that carry reset into the link logic
  assign rst_chk = rst || (rst_link_sr != 3'h0);
  // ****
  // busy length counter
  // ****
  logic [31:0] busy_cnt_ff;
  always_ff @(posedge clk_sys) begin
    if (rst || !program_busy) begin
      busy_cnt_ff <= 32'h0;
    end else begin
      busy_cnt_ff <= busy_cnt_ff + 32'h1;
    end
  end
  property p_odrain;
    @(posedge clk_link) disable iff (rst_chk) !sda_o;
  endproperty
  a_odrain: assert property (p_odrain) else $error("drive high");
  property p_oe_clk_low;
    @(posedge clk_link) disable iff (rst_chk) $changed(sda_oe) |-> !scl_i;
  endproperty
  a_oe_clk_low: assert property (p_oe_clk_low)
    else $error("data changed with clock high");
  property p_oe_hi;
    @(posedge clk_link) disable iff (rst_chk)
      scl_i ##1 scl_i |-> $stable(sda_oe);
  endproperty
  a_oe_hi: assert property (p_oe_hi) else $error("data unstable");
  property p_busy_quiet;
    @(posedge clk_sys) disable iff (rst) program_busy |-> !sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("response while programming");
  property p_busy_len;
    @(posedge clk_sys) disable iff (rst)
      $fell(program_busy) |-> busy_cnt_ff == PROG_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("bad length");
  property p_busy_max;
    @(posedge clk_sys) disable iff (rst) busy_cnt_ff <= PROG_CYCLES;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("too long");
  property p_busy_hold;
    @(posedge clk_sys) disable iff (rst)
      $rose(program_busy) |=> program_busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("short");
  property p_rst_idle;
    @(posedge clk_sys) disable iff (rst)
      $fell(rst) |-> !program_busy && !sda_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle");
  c_prog: cover property (@(posedge clk_sys) $fell(program_busy));
  c_ack: cover property (@(posedge clk_link) $rose(sda_oe));
  c_long: cover property (@(posedge clk_link) sda_oe [*8]);
endmodule : serw_top_chk
bind serw_top serw_top_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .chip_select_bit_high(chip_select_bit_high),
  .chip_select_bit_mid(chip_select_bit_mid),
  .chip_select_bit_low(chip_select_bit_low),
  .program_busy(program_busy));
`default_nettype wire

/* File: testbench/tb_serw_top.sv */
// self-checking bench for the serial eeprom command block
`default_nettype none
module tb_serw_top;
  timeunit 1ns;
  timeprecision 1ps;
  import serw_pkg::*;
  localparam int unsigned PC = 400;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic [2:0] cs = 3'h0;
  logic scl;
  logic m_low;
  logic sda_o;
  logic sda_oe;
  logic program_busy;
  logic saw_busy = 1'b0;
  logic [12:0] cnt;
  logic [7:0] row;
  logic [7:0] mem [int];
  int error_cnt = 0;
  int checks = 0;
  int seed;
  wire logic sda = !(m_low || sda_oe);
  initial forever #12.5 clk_sys = !clk_sys;
  initial begin
    #3.3;
    forever #7.5 clk_link = !clk_link;
  end
  serw_top #(.PROG_CYCLES(PC)) DUT (.clk_sys(clk_sys), .rst(rst),
    .clk_link(clk_link), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .chip_select_bit_high(cs[2]),
    .chip_select_bit_mid(cs[1]), .chip_select_bit_low(cs[0]),
    .program_busy(program_busy));
  serw_ctl_model u_ctl (.clk_link(clk_link), .sda_w(sda), .scl_o(scl),
    .sda_low(m_low));
  always @(posedge clk_sys) if (program_busy) saw_busy <= 1'b1;
  task chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  function automatic logic [7:0] dev(input logic rd);
    return {DEV_TYPE, cs, rd};
  endfunction : dev
  task automatic wb(input logic [7:0] b, input logic ea);
    logic [7:0] rx;
    logic a;
    u_ctl.byte_io(b, 1'b1, rx, a);
    chk("ack", 16'(a), 16'(ea));
  endtask : wb
  task automatic set_addr(input logic [12:0] a);
    u_ctl.start_c();
    wb(dev(1'b0), 1'b0);
    wb({3'($urandom), a[12:8]}, 1'b0);
    wb(a[7:0], 1'b0);
    cnt = a;
  endtask : set_addr
  task automatic pw(input logic [12:0] a, input int n);
    logic [7:0] d;
    logic k;
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      wb(d, 1'b0);
      cnt = {a[12:5], 5'(a[4:0] + 5'(i))};
      mem[cnt] = d;
    end
    cnt = {a[12:5], 5'(a[4:0] + 5'(n))};
    saw_busy = 1'b0;
    u_ctl.stop_c();
    u_ctl.start_c();
    wb(dev(1'b0), 1'b1);
    k = 1'b1;
    for (int j = 0; j < 20 && k; j++) begin
      u_ctl.start_c();
      u_ctl.byte_io(dev(1'b0), 1'b1, d, k);
    end
    chk("poll", 16'(k), 16'h0);
    chk("busy", 16'(saw_busy), 16'h1);
    u_ctl.stop_c();
  endtask : pw
  task automatic rd(input int n);
    logic [7:0] rx;
    logic a;
    u_ctl.start_c();
    wb(dev(1'b1), 1'b0);
    for (int i = 0; i < n; i++) begin
      u_ctl.byte_io(8'hFF, i == n - 1, rx, a);
      chk("rdata", 16'(rx), 16'(mem[cnt]));
      cnt++;
    end
    u_ctl.stop_c();
    chk("release", 16'(sda_oe), 16'h0);
  endtask : rd
  initial begin
    seed = $urandom(32'h289143C3);
    @(posedge clk_sys);
    cs <= 3'($urandom);
    @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_link);
    pw(13'h0000, 32);
    rd(1);
    pw(13'h1FFF, 1);
    row = 8'($urandom_range(254, 1));
    pw({row, 5'h1E}, 34);
    set_addr({row, 5'h00});
    rd(32);
    set_addr(13'h1FFF);
    rd(3);
    rd(1);
    u_ctl.start_c();
    wb({4'h9, cs, 1'b0}, 1'b1);
    u_ctl.start_c();
    wb({DEV_TYPE, ~cs, 1'b0}, 1'b1);
    u_ctl.stop_c();
    end_sim();
  end
  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end
endmodule : tb_serw_top
`default_nettype wire
